/* rtl/smtc_defs.vh */
// Constants of the static memory timing configuration block
// Operation
// - Same select and page: short access
// - New page bits: long first access
// - Select change breaks the page
// - Intervening access breaks the page
// - Four registers per select, 0x10 stride
// - Setup is 128*b5 plus b4:0
// - Pulse is 256*b6 plus b5:0
// - Page reads: strobe pulse next, select first
// - Cycle is 256*b8:7 plus b6:0
// - Hold is remainder of cycle
// - Mode bit 0 picks read control
// - Float optimization waits after next setup
// - Mode bit 1 picks write control
// - Wait mode: off, reserved, frozen, ready
// - Wait seen only in control pulse
// - Frozen wait halts counters
// - Ready wait stretches pulse end
// - Page size codes 4 to 32 bytes
// - Turnaround cycle after float cycles
`ifndef SMTC_DEFS_VH
`define SMTC_DEFS_VH
// Word index inside one chip-select block
`define SMTC_W_MODE     2'h3
// Byte addresses of the shared registers
`define SMTC_OFF_CSEND  8'h80
`define SMTC_OFF_SCR    8'h80
`define SMTC_OFF_KEYLO  8'h84
`define SMTC_OFF_KEYHI  8'h88
`define SMTC_OFF_STAT   8'hc0
`define SMTC_OFF_WPCTL  8'he4
`define SMTC_OFF_WPST   8'he8
// Reset values
`define SMTC_RST_SETUP  32'h01010101
`define SMTC_RST_PULSE  32'h01010101
`define SMTC_RST_CYCLE  32'h00030003
`define SMTC_RST_MODE   32'h10000003
`define SMTC_RST_ZERO   32'h00000000
// Field positions of setup, pulse and cycle words
`define SMTC_F_WSTB     0
`define SMTC_F_WCS      8
`define SMTC_F_RSTB     16
`define SMTC_F_RCS      24
`define SMTC_F_WCYC     0
`define SMTC_F_RCYC     16
// Field positions of the mode word
`define SMTC_M_RDCTL    0
`define SMTC_M_WRCTL    1
`define SMTC_M_WAIT     4
`define SMTC_M_BW       12
`define SMTC_M_FLT      16
`define SMTC_M_FOPT     20
`define SMTC_M_PEN      24
`define SMTC_M_PS       28
// Length weights of the upper field bits
`define SMTC_SETUP_HI   10'h080
`define SMTC_PULSE_HI   10'h100
// Wait mode codes
`define SMTC_WAIT_FRZ   2'h2
`define SMTC_WAIT_RDY   2'h3
// Page masks for the page size codes
`define SMTC_PS_4       2'h0
`define SMTC_PS_8       2'h1
`define SMTC_PS_16      2'h2
`define SMTC_MASK_4     24'hfffffc
`define SMTC_MASK_8     24'hfffff8
`define SMTC_MASK_16    24'hfffff0
`define SMTC_MASK_32    24'hffffe0
// Status word bit positions
`define SMTC_ST_BUSY    0
`define SMTC_ST_STALL   1
`define SMTC_ST_PAGE    2
`define SMTC_ST_CS      4
`define SMTC_ST_FLT     8
`endif

/* rtl/smtc_bank.v */
// Per chip-select timing register bank with staged and committed copies
`include "smtc_defs.vh"
module smtc_bank #(
    parameter NUM_CS = 4,
    parameter CSW    = 2
) (
    // Clock and reset
    input  wire                    pclk,
    input  wire                    presetn,
    // Write port
    input  wire                    wr_en,
    input  wire [CSW+1:0]          wr_idx,
    input  wire [31:0]             wr_data,
    // Registered read port
    input  wire                    rd_en,
    input  wire [CSW+1:0]          rd_idx,
    output reg  [31:0]             rd_data,
    // Committed timings, 128 bits per chip select
    output wire [NUM_CS*128-1:0]   active
);
    localparam DEPTH = 4 * NUM_CS;
    reg [31:0] stg [0:DEPTH-1];   // Words as written
    integer i;

    // Staged words take every write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                case (i % 4)
                    0: stg[i] <= `SMTC_RST_SETUP;
                    1: stg[i] <= `SMTC_RST_PULSE;
                    2: stg[i] <= `SMTC_RST_CYCLE;
                    default: stg[i] <= `SMTC_RST_MODE;
                endcase
            end
        end else if (wr_en) begin
            stg[wr_idx] <= wr_data;
        end
    end

    // Read data comes out of a register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= `SMTC_RST_ZERO;
        end else if (rd_en) begin
            rd_data <= stg[rd_idx];
        end
    end

    // Committed copy per chip select, loaded by a mode write
    genvar g;
    generate
        for (g = 0; g < NUM_CS; g = g + 1) begin : cs_act
            reg [127:0] act;
            wire commit = wr_en && (wr_idx[CSW+1:2] == g) && (wr_idx[1:0] == `SMTC_W_MODE);
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    act <= {`SMTC_RST_MODE, `SMTC_RST_CYCLE, `SMTC_RST_PULSE, `SMTC_RST_SETUP};
                end else if (commit) begin
                    act <= {wr_data, stg[4*g+2], stg[4*g+1], stg[4*g]};
                end
            end
            assign active[g*128 +: 128] = act;
        end
    endgenerate
endmodule

/* rtl/smtc_top.v */
// Static memory access sequencer with APB timing configuration
//
// The APB slave port was left to the implementer.
`include "smtc_defs.vh"
module smtc_top #(
    parameter NUM_CS = 4,
    parameter CSW    = 2
) (
    // Clock and reset
    input  wire                pclk,
    input  wire                presetn,
    // APB slave
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [7:0]          paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    // Access request port
    input  wire                acc_req,
    input  wire                acc_write,
    input  wire [CSW-1:0]      acc_cs,
    input  wire [23:0]         acc_addr,
    input  wire                other_access,
    output wire                acc_ready,
    output reg                 acc_done,
    // Memory pins
    output reg  [23:0]         mem_addr,
    output reg  [NUM_CS-1:0]   chip_sel_n,
    output reg                 read_strobe_n,
    output reg                 write_strobe_n,
    output reg  [1:0]          bus_width_sel,
    input  wire                ext_wait_n
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    // Field decoders
    function [9:0] setup_len;
        input [5:0] f;
        setup_len = {5'h00, f[4:0]} + (f[5] ? `SMTC_SETUP_HI : 10'h000);
    endfunction
    function [9:0] pulse_len;
        input [6:0] f;
        pulse_len = {4'h0, f[5:0]} + (f[6] ? `SMTC_PULSE_HI : 10'h000);
    endfunction
    function [9:0] cycle_len;
        input [8:0] f;
        cycle_len = {f[8:7], 8'h00} | {3'h0, f[6:0]};
    endfunction

    // Bank interface
    wire [NUM_CS*128-1:0] active;      // Committed timings
    wire [31:0]           bank_rd;     // Bank read data
    wire                  cs_range;    // Address inside a chip-select block
    wire                  apb_wr;      // Write taken this edge
    wire                  apb_rd_ph;   // Setup phase of a read
    reg                   rd_ready;    // Read data stands in prdata
    reg                   bad_addr;    // Unmapped address decode

    assign cs_range  = (paddr < `SMTC_OFF_CSEND) && (paddr[7:4] < NUM_CS);
    assign apb_wr    = psel && penable && pwrite;
    assign apb_rd_ph = psel && !penable && !pwrite;

    smtc_bank #(
        .NUM_CS (NUM_CS),
        .CSW    (CSW)
    ) u_bank (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (apb_wr && cs_range),
        .wr_idx  (paddr[CSW+3:2]),
        .wr_data (pwdata),
        .rd_en   (apb_rd_ph),
        .rd_idx  (paddr[CSW+3:2]),
        .rd_data (bank_rd),
        .active  (active)
    );

    // Shared registers
    reg [31:0] scr_en;       // Scrambling enable word
    reg [31:0] key_lo;       // Key low, write once
    reg [31:0] key_hi;       // Key high, write once
    reg        key_lo_done;  // Key low already written
    reg        key_hi_done;  // Key high already written
    reg [31:0] wp_ctrl;      // Write protect control word
    reg [31:0] stat_word;    // Live sequencer status

    // Address decode of mapped locations
    always @* begin
        bad_addr = 1'b1;
        if (cs_range) begin
            bad_addr = 1'b0;
        end else begin
            case (paddr)
                `SMTC_OFF_SCR, `SMTC_OFF_KEYLO, `SMTC_OFF_KEYHI,
                `SMTC_OFF_STAT, `SMTC_OFF_WPCTL, `SMTC_OFF_WPST: bad_addr = 1'b0;
                default: bad_addr = 1'b1;
            endcase
        end
    end

    // Writes complete at once, reads after one extra cycle
    assign pready  = pwrite ? 1'b1 : rd_ready;
    assign pslverr = psel && penable && pready && bad_addr;

    // Shared register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scr_en      <= `SMTC_RST_ZERO;
            key_lo      <= `SMTC_RST_ZERO;
            key_hi      <= `SMTC_RST_ZERO;
            key_lo_done <= 1'b0;
            key_hi_done <= 1'b0;
            wp_ctrl     <= `SMTC_RST_ZERO;
        end else if (apb_wr) begin
            case (paddr)
                `SMTC_OFF_SCR:   scr_en <= pwdata;
                `SMTC_OFF_WPCTL: wp_ctrl <= pwdata;
                `SMTC_OFF_KEYLO: begin
                    // Later writes are ignored
                    if (!key_lo_done) begin
                        key_lo      <= pwdata;
                        key_lo_done <= 1'b1;
                    end
                end
                `SMTC_OFF_KEYHI: begin
                    if (!key_hi_done) begin
                        key_hi      <= pwdata;
                        key_hi_done <= 1'b1;
                    end
                end
                default: scr_en <= scr_en;
            endcase
        end
    end

    // Read data capture in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata   <= `SMTC_RST_ZERO;
            rd_ready <= 1'b0;
        end else if (psel && penable && !pwrite && !rd_ready) begin
            rd_ready <= 1'b1;
            if (cs_range) begin
                prdata <= bank_rd;
            end else begin
                case (paddr)
                    `SMTC_OFF_SCR:   prdata <= scr_en;
                    `SMTC_OFF_STAT:  prdata <= stat_word;
                    `SMTC_OFF_WPCTL: prdata <= wp_ctrl;
                    default:         prdata <= `SMTC_RST_ZERO;
                endcase
            end
        end else begin
            rd_ready <= 1'b0;
        end
    end

    // Wait input resynchroniser
    reg wait_m;   // First stage
    reg wait_s;   // Second stage, high means ready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_m <= 1'b1;
            wait_s <= 1'b1;
        end else begin
            wait_m <= ext_wait_n;
            wait_s <= wait_m;
        end
    end

    // Sequencer state
    reg              state;      // Idle or running
    reg [9:0]        cnt;        // Cycle position inside the access
    reg [CSW-1:0]    cur_cs;     // Chip select of the access
    reg              cur_wr;     // Access is a write
    reg              cur_page;   // Access is a page-mode read
    reg              cur_hit;    // Page hit
    reg              cur_fhold;  // Float wait after setup requested
    reg [CSW-1:0]    prev_cs;    // Chip select of last access
    reg [23:0]       prev_addr;  // Address of last access
    reg              page_open;  // A page is open on prev_cs
    reg [4:0]        float_cnt;  // Remaining bus busy cycles
    reg [CSW-1:0]    float_cs;   // Owner of the floating bus

    // Timings of current and requesting chip selects
    wire [127:0] cfg  = active[cur_cs*128 +: 128];
    wire [127:0] rcfg = active[acc_cs*128 +: 128];
    wire [31:0]  c_set = cfg[31:0];
    wire [31:0]  c_pul = cfg[63:32];
    wire [31:0]  c_cyc = cfg[95:64];
    wire [31:0]  c_mod = cfg[127:96];
    wire [31:0]  r_mod = rcfg[127:96];
    wire [1:0]   wmode = c_mod[`SMTC_M_WAIT +: 2];

    // Phase lengths of the current access
    reg [9:0] stb_su;   // Strobe setup
    reg [9:0] stb_pl;   // Strobe pulse
    reg [9:0] chp_su;   // Chip select setup
    reg [9:0] chp_pl;   // Chip select pulse
    reg [9:0] ctl_su;   // Controlling signal setup
    reg [9:0] ctl_end;  // Controlling signal rising point
    reg [9:0] total;    // Whole access length
    reg [9:0] cyc;      // Programmed cycle
    reg       ctl_stb;  // Strobe controls the access

    always @* begin
        if (cur_wr) begin
            stb_su  = setup_len(c_set[`SMTC_F_WSTB +: 6]);
            stb_pl  = pulse_len(c_pul[`SMTC_F_WSTB +: 7]);
            chp_su  = setup_len(c_set[`SMTC_F_WCS +: 6]);
            chp_pl  = pulse_len(c_pul[`SMTC_F_WCS +: 7]);
            cyc     = cycle_len(c_cyc[`SMTC_F_WCYC +: 9]);
            ctl_stb = c_mod[`SMTC_M_WRCTL];
        end else begin
            stb_su  = setup_len(c_set[`SMTC_F_RSTB +: 6]);
            stb_pl  = pulse_len(c_pul[`SMTC_F_RSTB +: 7]);
            chp_su  = setup_len(c_set[`SMTC_F_RCS +: 6]);
            chp_pl  = pulse_len(c_pul[`SMTC_F_RCS +: 7]);
            cyc     = cycle_len(c_cyc[`SMTC_F_RCYC +: 9]);
            ctl_stb = c_mod[`SMTC_M_RDCTL];
        end
        if (cur_page) begin
            // Both signals low for the whole page access
            stb_su = 10'h000;
            chp_su = 10'h000;
            stb_pl = cur_hit ? pulse_len(c_pul[`SMTC_F_RSTB +: 7])
                             : pulse_len(c_pul[`SMTC_F_RCS +: 7]);
            chp_pl = stb_pl;
            cyc    = stb_pl;
        end
        ctl_su  = ctl_stb ? stb_su : chp_su;
        ctl_end = ctl_stb ? (stb_su + stb_pl) : (chp_su + chp_pl);
        // Hold is what remains of the cycle after the control pulse
        total   = (cyc > ctl_end) ? cyc : ctl_end;
    end

    // Stall conditions on the running count
    wire in_pulse = (cnt >= ctl_su) && (cnt < ctl_end) && !cur_page;
    wire frz_hold = (wmode == `SMTC_WAIT_FRZ) && in_pulse && !wait_s;
    wire rdy_hold = (wmode == `SMTC_WAIT_RDY) && in_pulse &&
                    (cnt == ctl_end - 10'h001) && !wait_s;
    wire flt_hold = cur_fhold && (cnt == ctl_su) && (float_cnt != 5'h00);
    wire hold     = frz_hold || rdy_hold || flt_hold;
    wire last     = (state == ST_RUN) && !hold && (cnt == total - 10'h001);
    wire ctl_rise = (state == ST_RUN) && !hold && (cnt == ctl_end - 10'h001);

    // Start decisions for a new request
    wire r_page   = r_mod[`SMTC_M_PEN] && !acc_write;
    wire r_bus    = (float_cnt == 5'h00) || (float_cs == acc_cs);
    wire r_opt    = r_mod[`SMTC_M_FOPT];
    reg  [23:0] r_mask;
    always @* begin
        case (r_mod[`SMTC_M_PS +: 2])
            `SMTC_PS_4:  r_mask = `SMTC_MASK_4;
            `SMTC_PS_8:  r_mask = `SMTC_MASK_8;
            `SMTC_PS_16: r_mask = `SMTC_MASK_16;
            default:     r_mask = `SMTC_MASK_32;
        endcase
    end
    wire r_hit = r_page && page_open && (prev_cs == acc_cs) &&
                 (((prev_addr ^ acc_addr) & r_mask) == 24'h000000);
    assign acc_ready = (state == ST_IDLE) && (r_bus || r_opt);
    wire start       = acc_req && acc_ready;

    // Access sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ST_IDLE;
            cnt       <= 10'h000;
            cur_cs    <= {CSW{1'b0}};
            cur_wr    <= 1'b0;
            cur_page  <= 1'b0;
            cur_hit   <= 1'b0;
            cur_fhold <= 1'b0;
            prev_cs   <= {CSW{1'b0}};
            prev_addr <= 24'h000000;
            page_open <= 1'b0;
            mem_addr  <= 24'h000000;
            acc_done  <= 1'b0;
        end else begin
            acc_done <= last;
            if (other_access) begin
                page_open <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state     <= ST_RUN;
                        cnt       <= 10'h000;
                        cur_cs    <= acc_cs;
                        cur_wr    <= acc_write;
                        cur_page  <= r_page;
                        cur_hit   <= r_hit && !other_access;
                        cur_fhold <= !r_bus;
                        mem_addr  <= acc_addr;
                        prev_cs   <= acc_cs;
                        prev_addr <= acc_addr;
                        // Any non-page access or new chip select closes the page
                        if (!r_page || prev_cs != acc_cs) begin
                            page_open <= 1'b0;
                        end
                    end
                end
                ST_RUN: begin
                    if (last) begin
                        state <= ST_IDLE;
                        cnt   <= 10'h000;
                        if (cur_page && !other_access) begin
                            page_open <= 1'b1;
                        end
                    end else if (!hold) begin
                        cnt <= cnt + 10'h001;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Bus float counter after the read control signal rises
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            float_cnt <= 5'h00;
            float_cs  <= {CSW{1'b0}};
        end else if (ctl_rise && !cur_wr) begin
            float_cnt <= {1'b0, c_mod[`SMTC_M_FLT +: 4]} + 5'h01;
            float_cs  <= cur_cs;
        end else if (float_cnt != 5'h00) begin
            float_cnt <= float_cnt - 5'h01;
        end
    end

    // Pin drivers, registered from the running count
    wire stb_on = (state == ST_RUN) && (cnt >= stb_su) && (cnt < stb_su + stb_pl);
    wire chp_on = (state == ST_RUN) && (cnt >= chp_su) && (cnt < chp_su + chp_pl);
    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_sel_n     <= {NUM_CS{1'b1}};
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            bus_width_sel  <= 2'h0;
        end else begin
            for (k = 0; k < NUM_CS; k = k + 1) begin
                chip_sel_n[k] <= !(chp_on && (cur_cs == k));
            end
            read_strobe_n  <= !(stb_on && !cur_wr);
            write_strobe_n <= !(stb_on && cur_wr);
            bus_width_sel  <= c_mod[`SMTC_M_BW +: 2];
        end
    end

    // Status word for software
    always @* begin
        stat_word = `SMTC_RST_ZERO;
        stat_word[`SMTC_ST_BUSY]    = state;
        stat_word[`SMTC_ST_STALL]   = (state == ST_RUN) && hold;
        stat_word[`SMTC_ST_PAGE]    = page_open;
        stat_word[`SMTC_ST_CS +: CSW] = cur_cs;
        stat_word[`SMTC_ST_FLT +: 5]  = float_cnt;
    end
endmodule

/* verification/smtc_sva.sv */
// Assertion checker for the static memory timing block
module smtc_sva #(
    parameter NUM_CS = 4
) (
    // Clock and reset
    input logic              pclk,
    input logic              presetn,
    // APB side
    input logic              psel,
    input logic              penable,
    input logic              pwrite,
    input logic [7:0]        paddr,
    input logic              pready,
    input logic              pslverr,
    // Access side and pins
    input logic              acc_done,
    input logic [23:0]       mem_addr,
    input logic [NUM_CS-1:0] chip_sel_n,
    input logic              read_strobe_n,
    input logic              write_strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Register bus answers
    chk_unmapped_err: assert property (psel && penable && pready && paddr >= 8'hec |-> pslverr)
        else $error("unmapped not flagged");
    chk_err_qualified: assert property (pslverr |-> pready && penable)
        else $error("stray error");
    chk_read_wait: assert property (psel && !penable && !pwrite |=> !pready ##1 pready)
        else $error("read latency");
    chk_write_nowait: assert property (psel && penable && pwrite |-> pready)
        else $error("write waited");
    // Memory pins and completion
    chk_one_select: assert property ($onehot0(~chip_sel_n))
        else $error("two chip selects low");
    chk_select_break: assert property (chip_sel_n != '1 && $past(chip_sel_n) != '1
        |-> chip_sel_n == $past(chip_sel_n))
        else $error("no select break");
    chk_strobe_excl: assert property (!(!read_strobe_n && !write_strobe_n))
        else $error("both strobes low");
    chk_done_pulse: assert property (acc_done |=> !acc_done)
        else $error("done too long");
    chk_write_addr: assert property (!write_strobe_n |-> $stable(mem_addr))
        else $error("address moved");
    // Main scenarios
    cover property (!read_strobe_n ##1 read_strobe_n);
    cover property (!write_strobe_n [*3]);
    cover property (psel && penable && pslverr);
endmodule

bind smtc_top smtc_sva #(.NUM_CS(NUM_CS)) smtc_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .acc_done(acc_done), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n));

/* verification/smtc_mem_model.sv */
// Behavioural external memory that answers with a wait line
module smtc_mem_model (
    // Clock and strobes
    input wire logic       pclk,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    // Cycles the part needs before it is ready
    input wire logic [3:0] stall,
    output logic           ext_wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left = 4'h0;  // Busy cycles still to go
    logic       ctl_d = 1'b0; // Control pulse seen last cycle
    // Busy span loaded at control fall
    always @(posedge pclk) begin
        ctl_d <= !(read_strobe_n && write_strobe_n);
        if (!(read_strobe_n && write_strobe_n) && !ctl_d)
            left <= stall;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    // Low while busy; released line rests at its pull-up level
    assign ext_wait_n = (left == 4'h0);
endmodule

/* verification/smtc_top_tb.sv */
// Self-checking bench for the static memory timing block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module smtc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, acc_req, acc_write, other_access;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, acc_ready, acc_done, read_strobe_n, write_strobe_n, ext_wait_n;
    logic [1:0]  acc_cs, bus_width_sel;
    logic [23:0] acc_addr, mem_addr;
    logic [3:0]  chip_sel_n, stall;
    int          n_fail = 0, total_checks = 0, len, pul, set, base, m;
    smtc_top smtc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .acc_req(acc_req), .acc_write(acc_write), .acc_cs(acc_cs),
        .acc_addr(acc_addr), .other_access(other_access), .acc_ready(acc_ready), .acc_done(acc_done),
        .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .bus_width_sel(bus_width_sel), .ext_wait_n(ext_wait_n));
    smtc_mem_model smtc_mem_model_inst (.pclk(pclk), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .stall(stall), .ext_wait_n(ext_wait_n));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One APB transfer into rd and err
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (m = 0; m < 20; m++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (m == 20) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One access; counts length, pulse and setup edges
    task automatic acc(input logic w, input logic [1:0] c, input logic [23:0] a);
        @(posedge pclk);
        acc_req <= 1'b1;
        acc_write <= w;
        acc_cs <= c;
        acc_addr <= a;
        m = 0;
        do begin
            @(posedge pclk);
            m++;
        end while (acc_ready !== 1'b1 && m < 50);
        acc_req <= 1'b0;
        len = 0;
        pul = 0;
        set = 0;
        while (acc_done !== 1'b1 && len < 2000) begin
            @(posedge pclk);
            len++;
            if ((read_strobe_n & write_strobe_n) === 1'b0) pul++;
            else if (pul == 0) set++;
        end
        if (len == 2000 || m == 50) n_fail++;
    endtask
    // Reset values, zero reads, reserved address
    task automatic t_regs();
        logic [31:0] rv [4] = '{32'h01010101, 32'h01010101, 32'h00030003, 32'h10000003};
        logic [7:0]  zr [5] = '{8'h80, 8'h84, 8'h88, 8'he4, 8'he8};
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK("timing reset", rv[i % 4], rd)
        end
        apb(1'b1, 8'h84, 32'h5a5a5a5a);
        apb(1'b1, 8'he8, 32'h1);
        foreach (zr[j]) begin
            apb(1'b0, zr[j], 32'h0);
            `CHK("shared reads zero", 32'h0, rd)
        end
        apb(1'b0, 8'hf0, 32'h0);
        `CHK("reserved error", 1'b1, err)
    endtask
    // Field weights and staged commit
    task automatic t_timing();
        int b_set;
        acc(1'b0, 2'h1, 24'h10);
        base = len;
        b_set = set;
        apb(1'b1, 8'h10, 32'h01210101);
        apb(1'b1, 8'h14, 32'h01020141);
        apb(1'b1, 8'h18, 32'h00ff0104);
        apb(1'b0, 8'h14, 32'h0);
        `CHK("pulse word", 32'h01020141, rd)
        acc(1'b0, 2'h1, 24'h10);
        `CHK("staged length", base, len)
        apb(1'b1, 8'h1c, 32'h10001003);
        acc(1'b0, 2'h1, 24'h10);
        `CHK("read length", base + 380, len)
        `CHK("read setup", b_set + 128, set)
        `CHK("read pulse", 2, pul)
        acc(1'b1, 2'h1, 24'h10);
        `CHK("write length", base + 513, len)
        `CHK("write pulse", 257, pul)
        `CHK("bus width", 2'h1, bus_width_sel)
    endtask
    // Page hits, misses and breaks
    task automatic t_page();
        int first;
        logic [23:0] a;
        apb(1'b1, 8'h24, 32'h06020101);
        for (int ps = 0; ps < 4; ps++) begin
            apb(1'b1, 8'h2c, 32'h01000003 | (32'(ps) << 28));
            a = 24'(4096 * (ps + 1));
            acc(1'b0, 2'h2, a);
            first = len;
            acc(1'b0, 2'h2, a + 24'(4 << ps) - 24'h1);
            `CHK("page hit", first - 4, len)
            acc(1'b0, 2'h2, a + 24'(4 << ps));
            `CHK("page miss", first, len)
        end
        other_access <= 1'b1;
        @(posedge pclk);
        other_access <= 1'b0;
        acc(1'b0, 2'h2, a + 24'(33));
        `CHK("break by other", first, len)
        acc(1'b0, 2'h3, a);
        acc(1'b0, 2'h2, a + 24'(34));
        `CHK("break by select", first, len)
    endtask
    // Wait modes off, frozen, ready
    task automatic t_wait();
        apb(1'b1, 8'h04, 32'h01050101);
        apb(1'b1, 8'h08, 32'h000a0003);
        apb(1'b1, 8'h0c, 32'h00000003);
        acc(1'b0, 2'h0, 24'h40);
        base = len;
        stall <= 4'h8;
        acc(1'b0, 2'h0, 24'h40);
        `CHK("wait off", base, len)
        apb(1'b1, 8'h0c, 32'h00000023);
        acc(1'b0, 2'h0, 24'h40);
        `CHK("frozen longer", 1'b1, len > base)
        apb(1'b1, 8'h0c, 32'h00000033);
        acc(1'b0, 2'h0, 24'h40);
        `CHK("ready longer", 1'b1, len > base)
    endtask
    // Watchdog
    initial begin
        #500us;
        n_fail++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, acc_req, acc_write, other_access} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        acc_cs = 2'h0;
        acc_addr = 24'h0;
        stall = 4'h0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_timing();
        t_page();
        t_wait();
        wrap_up();
    end
endmodule
